/* tdr_pkg.sv */
// Purpose: Shared constants and types of the tick-divided reload timers.
// Assumes: 32-bit Avalon-MM register bus with byte addresses.
// Notes: Offsets are byte addresses; each register takes one aligned word.
`default_nettype none

package tdr_pkg;

	// ==========================================================================
	// Register map
	localparam int TDR_AW = 6;
	localparam int TDR_NUM_TIMERS = 3;
	localparam logic [5:0] TDR_OFF_DIV = 6'h04;
	localparam logic [5:0] TDR_OFF_COUNT = 6'h08;
	localparam logic [5:0] TDR_OFF_RELOAD = 6'h14;
	localparam logic [5:0] TDR_OFF_CTRL = 6'h20;
	localparam logic [5:0] TDR_OFF_IRQ_STAT = 6'h2c;
	localparam logic [5:0] TDR_OFF_IRQ_MASK = 6'h30;
	localparam logic [5:0] TDR_STRIDE = 6'h04;

	// ==========================================================================
	// Fields and reset values
	localparam int TDR_DIV_W = 18;
	localparam logic [17:0] TDR_DIV_RST = 18'h03d08;
	localparam logic [31:0] TDR_COUNT_RST = 32'h00000000;
	localparam logic [31:0] TDR_RELOAD_RST = 32'h00000000;
	localparam int TDR_CTRL_FORCE = 0;
	localparam int TDR_CTRL_ENA = 1;
	localparam int TDR_CTRL_SINGLE = 2;

	// Avalon response codes.
	localparam logic [1:0] TDR_RESP_OKAY = 2'h0;
	localparam logic [1:0] TDR_RESP_DECERR = 2'h3;

	// ==========================================================================
	// Base clock synthesis from the system clock
	localparam int TDR_SYS_KHZ = 250000;
	localparam int TDR_BASE_KHZ = 156250;
	localparam int TDR_ACC_W = 3;
	localparam int TDR_BASE_INC = TDR_BASE_KHZ * (2 ** TDR_ACC_W) / TDR_SYS_KHZ;

	// Control bits of one timer as software sees them.
	typedef struct packed {
		logic single;
		logic ena;
	} tdr_ctrl_t;

endpackage

`default_nettype wire

/* tdr_timers.sv */
// Purpose: Shared tick generator driving three reloading down-counting timers.
// Assumes: Avalon-MM slave on clk_sys_i at 250 MHz; asynchronous active-low reset.
// Notes: The base clock is produced as a fractional enable of the system clock.
//
// Summary of operation
// (R01) Ticks come from a 156.25 MHz base clock by counting base cycles.
// (R02) Tick rate is base clock divided by divider field plus one.
// (R03) Divider resets to its default, one tick every 100 us.
// (R04) One tick feeds all timers; the watchdog does not use it.
// (R05) Software keeps the tick period at or above 0.1 us.
// (R06) After a divider change timers may run unsettled for up to 2 ms.
// (R07) Each timer has a 32-bit readable, writable count; decrements per tick when enabled.
// (R08) Interrupt fires when a tick arrives while the count is already zero.
// (R09) Outside single-run mode the reload value is loaded and counting continues.
// (R10) Reload register resets to zero and is copied into count on wrap.
// (R11) Control bit 1 enables counting and resets to zero.
// (R12) Control bit 2 makes the timer disable itself after its interrupt.
// (R13) In single-run mode enable clears in the same event as the interrupt.
// (R14) Writing 1 to control bit 0 copies reload into count at once.
// (R15) Force reload with enable loads first, then counts from the reload value.
// (R16) Three independent timers, each with own registers and interrupt, share one tick.
// (R17) The force-reload bit clears itself and always reads zero.
`timescale 1ns/1ns
`default_nettype none

module tdr_timers
	import tdr_pkg::*;
#(
	parameter int NUM_TIMERS = TDR_NUM_TIMERS
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [TDR_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic [1:0] avs_response_o,
	output logic avs_waitrequest_o,
	output logic tick_o,
	output logic [NUM_TIMERS-1:0] timer_irq_o,
	output logic irq_o
);

	// ==========================================================================
	// Elaboration checks
	// The map leaves room for three timers per bank, and the base enable must be exact.
	generate
		if (NUM_TIMERS < 1 || NUM_TIMERS > 3) begin : g_bad_num
			$error("NUM_TIMERS must lie between 1 and 3.");
		end
		if (TDR_BASE_INC * TDR_SYS_KHZ != TDR_BASE_KHZ * (2 ** TDR_ACC_W)) begin : g_bad_base
			$error("Base clock is not an exact fraction of the system clock.");
		end
	endgenerate

	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] tdr_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ==========================================================================
	// Bus slave
	logic waitreq;
	logic [31:0] rdata;
	logic [1:0] resp;
	logic [TDR_DIV_W-1:0] div;
	logic [NUM_TIMERS-1:0] status;
	logic [NUM_TIMERS-1:0] mask;
	logic [NUM_TIMERS-1:0] next_status;
	logic [31:0] count [NUM_TIMERS];
	logic [31:0] reload [NUM_TIMERS];
	tdr_ctrl_t ctrl [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] evt;
	logic [NUM_TIMERS-1:0] sel_cnt;
	logic [NUM_TIMERS-1:0] sel_rld;
	logic [NUM_TIMERS-1:0] sel_ctl;
	logic [31:0] tmr_rdata [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] tmr_hit;
	logic tick;

	// Request decode; a request is taken at the edge where waitrequest is low.
	wire logic req = avs_read_i | avs_write_i;
	wire logic take = req & ~waitreq;
	wire logic wr_take = take & avs_write_i;
	wire logic rd_take = take & avs_read_i;
	wire logic sel_div = (avs_address_i == TDR_OFF_DIV);
	wire logic sel_stat = (avs_address_i == TDR_OFF_IRQ_STAT);
	wire logic sel_mask = (avs_address_i == TDR_OFF_IRQ_MASK);
	wire logic hit = sel_div | sel_stat | sel_mask | (|tmr_hit);

	// Read selection; unmapped words, including the watchdog slot, read zero.
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h00000000;
		if (sel_div) begin
			next_rdata = {{(32 - TDR_DIV_W){1'b0}}, div};
		end
		if (sel_stat) begin
			next_rdata = {{(32 - NUM_TIMERS){1'b0}}, status};
		end
		if (sel_mask) begin
			next_rdata = {{(32 - NUM_TIMERS){1'b0}}, mask};
		end
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (tmr_hit[i]) begin
				next_rdata = tmr_rdata[i];
			end
		end
	end

	// Every access waits exactly one cycle; read data is captured during that wait.
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			waitreq <= 1'b1;
			rdata <= 32'h00000000;
			resp <= TDR_RESP_OKAY;
		end else begin
			waitreq <= ~(req & waitreq);
			if (req & waitreq) begin
				rdata <= avs_read_i ? next_rdata : 32'h00000000;
				resp <= hit ? TDR_RESP_OKAY : TDR_RESP_DECERR;
			end
		end
	end

	assign avs_waitrequest_o = waitreq;
	assign avs_readdata_o = rdata;
	assign avs_response_o = resp;

	// ==========================================================================
	// Divider and mask registers
	// The merged word is a named wire because a function result cannot be sliced.
	wire logic [31:0] div_merged = tdr_merge({{(32 - TDR_DIV_W){1'b0}}, div}, avs_writedata_i,
		avs_byteenable_i);
	// The interrupt outputs use the mask of the next cycle, so a mask write shows at once.
	wire logic [NUM_TIMERS-1:0] next_mask = (wr_take & sel_mask & avs_byteenable_i[0]) ?
		avs_writedata_i[NUM_TIMERS-1:0] : mask;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div <= TDR_DIV_RST; // R03
			mask <= '0;
		end else if (wr_take) begin
			if (sel_div) begin
				div <= div_merged[TDR_DIV_W-1:0];
			end
			mask <= next_mask;
		end
	end

	// ==========================================================================
	// Tick generator
	// A 3-bit phase accumulator yields 5 base enables in every 8 system cycles,
	// which is 156.25 MHz on average; jitter is one system cycle at most.
	logic [TDR_ACC_W-1:0] base_acc;
	logic [TDR_DIV_W-1:0] pre_cnt;
	wire logic [TDR_ACC_W:0] base_sum = {1'b0, base_acc} + (TDR_ACC_W + 1)'(TDR_BASE_INC);
	wire logic base_en = base_sum[TDR_ACC_W];
	// Greater-or-equal lets a lowered divider take hold at once instead of
	// waiting for the prescaler to wrap its full 18-bit range.
	wire logic pre_end = (pre_cnt >= div);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			base_acc <= '0;
			pre_cnt <= '0;
			tick <= 1'b0;
		end else begin
			base_acc <= base_sum[TDR_ACC_W-1:0]; // R01
			tick <= base_en & pre_end; // R02
			if (base_en) begin
				pre_cnt <= pre_end ? '0 : pre_cnt + 1'b1; // R02 R06
			end
		end
	end

	assign tick_o = tick;

	// ==========================================================================
	// Timers
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
			wire logic [5:0] step = 6'(gi * 4);
			wire logic s_cnt = (avs_address_i == TDR_OFF_COUNT + step);
			wire logic s_rld = (avs_address_i == TDR_OFF_RELOAD + step);
			wire logic s_ctl = (avs_address_i == TDR_OFF_CTRL + step);
			wire logic wr_cnt = wr_take & s_cnt;
			wire logic wr_rld = wr_take & s_rld;
			wire logic wr_ctl = wr_take & s_ctl & avs_byteenable_i[0];
			wire logic force_rld = wr_ctl & avs_writedata_i[TDR_CTRL_FORCE];

			assign sel_cnt[gi] = s_cnt;
			assign sel_rld[gi] = s_rld;
			assign sel_ctl[gi] = s_ctl;
			assign tmr_hit[gi] = sel_cnt[gi] | sel_rld[gi] | sel_ctl[gi];
			// The force bit is never stored, so it reads back as zero.
			assign tmr_rdata[gi] = s_cnt ? count[gi] : s_rld ? reload[gi] :
				s_ctl ? {29'h0, ctrl[gi].single, ctrl[gi].ena, 1'b0} : 32'h0; // R17
			// The interrupt event is a tick seen while the count already sits at zero.
			assign evt[gi] = tick & ctrl[gi].ena & (count[gi] == 32'h0); // R04 R08 R16

			logic [31:0] next_count;
			tdr_ctrl_t next_ctrl;
			// Software writes override the hardware step of the same cycle.
			always_comb begin
				next_count = count[gi];
				next_ctrl = ctrl[gi];
				if (evt[gi]) begin
					next_count = reload[gi]; // R09 R10
					if (ctrl[gi].single) begin
						next_ctrl.ena = 1'b0; // R12 R13
					end
				end else if (tick & ctrl[gi].ena) begin
					next_count = count[gi] - 32'h1; // R07
				end
				if (wr_cnt) begin
					next_count = tdr_merge(count[gi], avs_writedata_i, avs_byteenable_i); // R07
				end
				if (wr_ctl) begin
					next_ctrl.ena = avs_writedata_i[TDR_CTRL_ENA]; // R11
					next_ctrl.single = avs_writedata_i[TDR_CTRL_SINGLE]; // R12
				end
				if (force_rld) begin
					next_count = reload[gi]; // R14 R15
				end
			end

			always_ff @(posedge clk_sys_i or negedge nrst_i) begin
				if (!nrst_i) begin
					count[gi] <= TDR_COUNT_RST;
					reload[gi] <= TDR_RELOAD_RST; // R10
					ctrl[gi] <= '0; // R11
				end else begin
					count[gi] <= next_count;
					ctrl[gi] <= next_ctrl;
					if (wr_rld) begin
						reload[gi] <= tdr_merge(reload[gi], avs_writedata_i, avs_byteenable_i);
					end
				end
			end

			// ------------------------------------------------------------------
			// Checks of one timer
			property p_decrement;
				@(posedge clk_sys_i) disable iff (!nrst_i)
				(tick && ctrl[gi].ena && count[gi] != 32'h0 && !wr_cnt && !force_rld)
					|=> count[gi] == $past(count[gi]) - 32'h1;
			endproperty
			a_decrement: assert property (p_decrement) else $error("Count did not step down."); // R07

			property p_irq_on_zero;
				@(posedge clk_sys_i) disable iff (!nrst_i)
				(tick && ctrl[gi].ena && count[gi] == 32'h0) |=> status[gi];
			endproperty
			a_irq_on_zero: assert property (p_irq_on_zero) else $error("Zero tick raised no interrupt."); // R08

			property p_reload;
				@(posedge clk_sys_i) disable iff (!nrst_i)
				(evt[gi] && !wr_cnt) |=> count[gi] == $past(reload[gi]);
			endproperty
			a_reload: assert property (p_reload) else $error("Count did not reload on wrap."); // R09

			property p_single;
				@(posedge clk_sys_i) disable iff (!nrst_i)
				(evt[gi] && ctrl[gi].single && !wr_ctl) |=> !ctrl[gi].ena;
			endproperty
			a_single: assert property (p_single) else $error("Single-run timer stayed enabled."); // R13

			property p_force;
				@(posedge clk_sys_i) disable iff (!nrst_i)
				force_rld |=> count[gi] == $past(reload[gi]) && ctrl[gi].ena == $past(avs_writedata_i[1]);
			endproperty
			a_force: assert property (p_force) else $error("Forced reload missed."); // R15

			property p_hold;
				@(posedge clk_sys_i) disable iff (!nrst_i)
				(!ctrl[gi].ena && !wr_cnt && !force_rld) |=> $stable(count[gi]);
			endproperty
			a_hold: assert property (p_hold) else $error("Stopped timer moved."); // R11
		end
	endgenerate

	// ==========================================================================
	// Interrupt status, mask and outputs
	// A read clears only the bits it returned, so an event landing during the
	// bus wait is kept; a new event also wins over the clear of its own bit.
	wire logic stat_clr = rd_take & sel_stat;
	assign next_status = (status & ~(stat_clr ? rdata[NUM_TIMERS-1:0] : '0)) | evt;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			status <= '0;
			timer_irq_o <= '0;
			irq_o <= 1'b0;
		end else begin
			status <= next_status;
			timer_irq_o <= next_status & next_mask; // R16
			irq_o <= |(next_status & next_mask);
		end
	end

	// Status bits are sticky: only a read of the status word may clear them.
	property p_status_sticky;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		!stat_clr |=> (status & $past(status)) == $past(status);
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("Status bit dropped without a read.");

	// ==========================================================================
	// Shared checks
	sequence s_bus_req;
		req && waitreq;
	endsequence

	sequence s_bus_ack;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence

	property p_bus_ack;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		s_bus_req |=> s_bus_ack;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("Bus answer not one cycle later.");

	// Unmapped words must answer with the decode error and zero data.
	property p_bus_resp;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		(req && waitreq && !hit) |=> avs_response_o == TDR_RESP_DECERR && avs_readdata_o == 32'h00000000;
	endproperty
	a_bus_resp: assert property (p_bus_resp) else $error("Unmapped access not refused.");

	// Helper flag: the divider has not been written since reset.
	logic div_untouched;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_untouched <= 1'b1;
		end else if (wr_take & sel_div) begin
			div_untouched <= 1'b0;
		end
	end

	property p_div_default;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		div_untouched |-> div == TDR_DIV_RST;
	endproperty
	a_div_default: assert property (p_div_default) else $error("Divider lost its default."); // R03

	property p_tick_gap;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		// At most two base enables come back to back, so a divider of one still leaves two idle cycles.
		(tick && div != '0 && !(wr_take && sel_div)) |=> !tick [*2];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("Ticks came too close."); // R02

	property p_tick_cause;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(tick) |-> $past(pre_cnt) >= $past(div) && $past(base_en);
	endproperty
	a_tick_cause: assert property (p_tick_cause) else $error("Tick without prescaler end."); // R01

	property p_irq_out;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		irq_o == |(status & mask);
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("Interrupt output mismatch.");

	// Each timer line follows its own status bit through the mask.
	property p_timer_irq_out;
		@(posedge clk_sys_i) disable iff (!nrst_i)
		timer_irq_o == (status & mask);
	endproperty
	a_timer_irq_out: assert property (p_timer_irq_out) else $error("Timer interrupt line mismatch."); // R16

endmodule

`default_nettype wire

/* tdr_timers_tb.sv */
// Purpose: Self-checking bench for the tick-divided reload timers.
// Assumes: Reads answer after one wait cycle; expected read data queue in order.
// Notes: Small divider values keep every timer scenario short.
`timescale 1ns/1ns
`default_nettype none

module tdr_timers_tb
	import tdr_pkg::*;
;
	logic clk_sys_i;
	logic nrst_i;
	logic [5:0] avs_address_i;
	logic avs_read_i;
	logic avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [3:0] avs_byteenable_i;
	logic [31:0] avs_readdata_o;
	logic [1:0] avs_response_o;
	logic avs_waitrequest_o;
	logic tick_o;
	logic [2:0] timer_irq_o;
	logic irq_o;
	logic [31:0] exp_d[$];
	logic [1:0] exp_r[$];
	logic [31:0] ed;
	logic [1:0] er;
	logic [31:0] seed;
	logic [31:0] rl;
	int bad_count;
	int tests_run;
	int tick_cnt;
	int cycles;
	int base;

	tdr_timers tdr_timers_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o), .tick_o(tick_o),
		.timer_irq_o(timer_irq_o), .irq_o(irq_o));

	// ==========================================================================
	// Helpers
	// Pseudo-random values come from a fixed shift register so every run repeats.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [5:0] off(input logic [5:0] b, input int i);
		return b + 6'(int'(TDR_STRIDE) * i);
	endfunction

	task automatic finish_test();
		$display("Mismatches %0d, comparisons %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	// One Avalon access; the request is held until waitrequest is sampled low.
	task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk_sys_i);
		if (rd) begin
			exp_d.push_back(d);
			exp_r.push_back(r);
		end
		avs_address_i <= a;
		avs_writedata_i <= rd ? 32'h00000000 : d;
		avs_read_i <= rd;
		avs_write_i <= !rd;
		// Only the bench timeout ends a wait that never sees waitrequest low.
		do begin
			@(posedge clk_sys_i);
		end while (avs_waitrequest_o !== 1'b0);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 3000) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk(irq_o === 1'b1, "interrupt did not arrive");
	endtask

	// ==========================================================================
	// Clock, timeout and monitors
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	// The ceiling is far above the few thousand cycles the scenarios need.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			$display("BAD %0t run did not finish", $time);
			finish_test();
		end
	end

	// Tick pulses are counted with a non-blocking update so readers see a settled value.
	always @(posedge clk_sys_i) begin
		if (tick_o === 1'b1) begin
			tick_cnt <= tick_cnt + 1;
		end
	end

	// Read results are matched against the oldest expectation when waitrequest is low.
	always @(posedge clk_sys_i) begin
		if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
			ed = exp_d.pop_front();
			er = exp_r.pop_front();
			tests_run++;
			if (avs_readdata_o !== ed || avs_response_o !== er) begin
				bad_count++;
				$display("BAD %0t read %h gave %h/%h, expected %h/%h", $time, avs_address_i,
					avs_readdata_o, avs_response_o, ed, er);
			end
		end
	end

	// ==========================================================================
	// Main sequence
	initial begin
		nrst_i = 1'b0;
		avs_address_i = 6'h00;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h00000000;
		avs_byteenable_i = 4'hf;
		seed = 32'h63df;
		bad_count = 0;
		tests_run = 0;
		tick_cnt = 0;
		cycles = 0;
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		// Reset values, then the unmapped places below and above the map.
		bus(1, TDR_OFF_DIV, 32'(TDR_DIV_RST), TDR_RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			bus(1, off(TDR_OFF_COUNT, i), TDR_COUNT_RST, TDR_RESP_OKAY);
			bus(1, off(TDR_OFF_RELOAD, i), TDR_RELOAD_RST, TDR_RESP_OKAY);
			bus(1, off(TDR_OFF_CTRL, i), 32'h00000000, TDR_RESP_OKAY);
		end
		bus(1, TDR_OFF_IRQ_STAT, 32'h00000000, TDR_RESP_OKAY);
		bus(1, TDR_OFF_IRQ_MASK, 32'h00000000, TDR_RESP_OKAY);
		bus(1, 6'h00, 32'h00000000, TDR_RESP_DECERR);
		bus(0, 6'h34, 32'hffffffff, TDR_RESP_OKAY);
		bus(1, 6'h34, 32'h00000000, TDR_RESP_DECERR);
		// Divider 15 is the fastest legal setting: one tick per sixteen base enables, below 10 MHz.
		bus(0, TDR_OFF_DIV, 32'h0000000f, TDR_RESP_OKAY);
		bus(1, TDR_OFF_DIV, 32'h0000000f, TDR_RESP_OKAY);
		repeat (50) @(posedge clk_sys_i);
		base = tick_cnt;
		repeat (1024) @(posedge clk_sys_i);
		chk((tick_cnt - base) >= 39 && (tick_cnt - base) <= 41, "tick rate off");
		// Periodic timer 0: interrupt on the tick that finds zero, then reload and go on.
		bus(0, TDR_OFF_IRQ_MASK, 32'h00000001, TDR_RESP_OKAY);
		bus(0, TDR_OFF_RELOAD, 32'h00000002, TDR_RESP_OKAY);
		bus(0, TDR_OFF_COUNT, 32'h00000001, TDR_RESP_OKAY);
		bus(1, TDR_OFF_COUNT, 32'h00000001, TDR_RESP_OKAY);
		bus(0, TDR_OFF_CTRL, 32'h00000002, TDR_RESP_OKAY);
		@(posedge clk_sys_i);
		base = tick_cnt;
		wait_irq();
		chk(tick_cnt - base == 2 && timer_irq_o === 3'b001, "first interrupt tick count");
		bus(1, TDR_OFF_IRQ_STAT, 32'h00000001, TDR_RESP_OKAY);
		bus(1, TDR_OFF_COUNT, 32'h00000002, TDR_RESP_OKAY);
		base = tick_cnt;
		wait_irq();
		chk(tick_cnt - base == 3, "reloaded period wrong");
		bus(0, TDR_OFF_CTRL, 32'h00000000, TDR_RESP_OKAY);
		bus(1, TDR_OFF_IRQ_STAT, 32'h00000001, TDR_RESP_OKAY);
		// The cleared output is only visible once the clearing edge has passed.
		@(posedge clk_sys_i);
		chk(irq_o === 1'b0, "interrupt stayed high after status read");
		// Single-run timer 1 stops itself on its interrupt and keeps the reload.
		seed = lfsr_next(seed);
		rl = {8'h00, seed[23:0]};
		bus(0, TDR_OFF_IRQ_MASK, 32'h00000002, TDR_RESP_OKAY);
		bus(0, off(TDR_OFF_RELOAD, 1), rl, TDR_RESP_OKAY);
		bus(1, off(TDR_OFF_RELOAD, 1), rl, TDR_RESP_OKAY);
		bus(0, off(TDR_OFF_CTRL, 1), 32'h00000006, TDR_RESP_OKAY);
		wait_irq();
		chk(timer_irq_o === 3'b010, "wrong timer interrupt line");
		bus(1, off(TDR_OFF_CTRL, 1), 32'h00000004, TDR_RESP_OKAY);
		bus(1, off(TDR_OFF_COUNT, 1), rl, TDR_RESP_OKAY);
		bus(1, TDR_OFF_IRQ_STAT, 32'h00000002, TDR_RESP_OKAY);
		// Forced reload alone, then together with enable right after a tick.
		seed = lfsr_next(seed);
		rl = 32'(seed[1:0]) + 32'h00000001;
		bus(0, off(TDR_OFF_RELOAD, 2), rl, TDR_RESP_OKAY);
		bus(0, off(TDR_OFF_CTRL, 2), 32'h00000001, TDR_RESP_OKAY);
		bus(1, off(TDR_OFF_COUNT, 2), rl, TDR_RESP_OKAY);
		bus(1, off(TDR_OFF_CTRL, 2), 32'h00000000, TDR_RESP_OKAY);
		bus(0, off(TDR_OFF_COUNT, 2), 32'h00000000, TDR_RESP_OKAY);
		while (tick_o !== 1'b1) @(posedge clk_sys_i);
		bus(0, off(TDR_OFF_CTRL, 2), 32'h00000003, TDR_RESP_OKAY);
		bus(1, off(TDR_OFF_COUNT, 2), rl, TDR_RESP_OKAY);
		bus(1, off(TDR_OFF_CTRL, 2), 32'h00000002, TDR_RESP_OKAY);
		// Timer 2 is masked: status sets but the interrupt output stays low.
		base = tick_cnt;
		while (tick_cnt - base < 7) begin
			@(posedge clk_sys_i);
			chk(irq_o === 1'b0, "masked timer raised interrupt");
		end
		bus(1, TDR_OFF_IRQ_STAT, 32'h00000004, TDR_RESP_OKAY);
		bus(0, TDR_OFF_IRQ_MASK, 32'h00000004, TDR_RESP_OKAY);
		wait_irq();
		chk(timer_irq_o === 3'b100, "timer 2 interrupt line");
		repeat (3) @(posedge clk_sys_i);
		finish_test();
	end
endmodule

`default_nettype wire
